// ==== rtl/nvpot_regs.svh ====
`ifndef NVPOT_REGS_SVH
`define NVPOT_REGS_SVH

// ****************************************************************
// Register map, reset values and timing.
// ****************************************************************
`define NVPOT_WIPER_ADDR    8'h00
`define NVPOT_CTRL_ADDR     8'h02
`define NVPOT_WIPER_RST     8'h40
`define NVPOT_CTRL_RST      8'h00
`define NVPOT_MODE_BIT      7
`define NVPOT_SLAVE_BASE    5'h0a
`define NVPOT_CLK_PERIOD_NS 10
`define NVPOT_PROG_TIME_NS  10000000
`define NVPOT_PROG_CYCLES   (`NVPOT_PROG_TIME_NS / `NVPOT_CLK_PERIOD_NS)
`define NVPOT_RECALL_CYCLES 2

`endif

// ==== rtl/nvpot_pkg.sv ====
package nvpot_pkg;

  // ****************************************************************
  // Types shared by the bank and its storage.
  // ****************************************************************
  typedef enum logic [5:0] {
    NVPOT_IDLE   = 6'b00_0001,
    NVPOT_RECV   = 6'b00_0010,
    NVPOT_ACK    = 6'b00_0100,
    NVPOT_SEND   = 6'b00_1000,
    NVPOT_MACK   = 6'b01_0000,
    NVPOT_IGNORE = 6'b10_0000
  } nvpot_state_e;

  // Conditions seen on the synchronised serial pins in one cycle.
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } nvpot_bus_s;

  typedef logic [6:0] nvpot_wiper_t;

endpackage

// ==== rtl/nvpot_nvmem.sv ====
`timescale 1ns/10ps

`include "nvpot_regs.svh"

// ****************************************************************
// Nonvolatile initial position storage.
// ****************************************************************
module nvpot_nvmem
  import nvpot_pkg::*;
#(
  parameter int WIDTH = 7
) (
  input  wire logic             clock,
  input  wire logic             clock_en,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data_q
);

  // Factory content; this cell is not touched by the reset on purpose.
  // It is set where it is declared, because only the program process may write it.
  logic [WIDTH-1:0] cell_q = WIDTH'(`NVPOT_WIPER_RST);

  // Program the cell.
  always_ff @(posedge clock) begin
    if (clock_en && wr_en) begin
      cell_q <= wr_data;
    end
  end

  // Registered read port.
  always_ff @(posedge clock) begin
    if (clock_en && rd_en) begin
      rd_data_q <= cell_q;
    end
  end

endmodule // nvpot_nvmem

// ==== rtl/nvpot_bank.sv ====
`timescale 1ns/10ps

`include "nvpot_regs.svh"

// Summary of operation
// R1: Power-up copies stored value into wiper.
// R2: Wiper register at 00h, default 40h.
// R3: Control register at 02h holds mode.
// R4: Reads of 00h return wiper register.
// R5: Mode one writes wiper only, no programming.
// R6: Toggling mode leaves wiper and storage alone.
// R7: Control register resets to 00h.
// R8: Tap is wiper value 0 to 127.
// R9: Base write address byte is 50h.
// R10: Each select pin sets one address bit.
// R11: Programming starts only at STOP.
// R12: Recall delay runs from reset to recall.
// R13: Works at standard and fast bus rates.
// R14: Wiper updates at ack, repeated START skips programming.
// R15: No address ack while programming.
// R16: Mismatched address ignored until next START.
// R17: Second byte is pointer, reads use pointer.
// R18: Mode is bit 7, others reserved zero.
// R19: Wiper MSB ignored, unmapped reads zero.
module nvpot_bank
  import nvpot_pkg::*;
#(
  parameter int PROG_CYCLES = `NVPOT_PROG_CYCLES
) (
  input  wire logic  clock,
  input  wire logic  clock_en,
  input  wire logic  rst,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  input  wire logic  addr_select_low_bit,
  input  wire logic  addr_select_high_bit,
  output logic [6:0] wiper_tap,
  output logic       eeprom_busy,
  output logic       recall_done
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [2:0]   scl_sync_q;
  logic [2:0]   sda_sync_q;
  logic [1:0]   asel_lo_q;
  logic [1:0]   asel_hi_q;
  nvpot_bus_s   bus;
  nvpot_state_e state_q;
  logic [3:0]   bitcnt_q;
  logic [7:0]   shreg_q;
  logic [1:0]   idx_q;
  logic         rw_q;
  logic [7:0]   ptr_q;
  nvpot_wiper_t wiper_q;
  logic         mode_q;
  logic         pend_q;
  logic         busy_q;
  logic [31:0]  prog_cnt_q;
  logic [1:0]   recall_cnt_q;
  logic         recall_q;
  logic         mem_wr;
  logic         mem_rd;
  nvpot_wiper_t mem_rd_data;
  logic [6:0]   slave_addr;
  logic         byte_done;
  logic [7:0]   rd_word;

  // Register read decode; anything unmapped reads as zero.
  function automatic logic [7:0] reg_read(input logic [7:0] addr,
                                          input nvpot_wiper_t wiper,
                                          input logic mode);
    logic [7:0] data;
    data = 8'h00;                                                         // R19
    if (addr == `NVPOT_WIPER_ADDR) begin
      data = {1'b0, wiper};                                               // R4
    end else if (addr == `NVPOT_CTRL_ADDR) begin
      data = {mode, 7'h00};                                               // R18
    end
    return data;
  endfunction

  // ****************************************************************
  // Pin synchronisers and bus condition detection.
  // ****************************************************************

  // Two flops before use; the third holds the previous settled level.
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      asel_lo_q  <= 2'h0;
      asel_hi_q  <= 2'h0;
    end else if (clock_en) begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      asel_lo_q  <= {asel_lo_q[0], addr_select_low_bit};
      asel_hi_q  <= {asel_hi_q[0], addr_select_high_bit};
    end
  end

  // Sampling at 10 ns resolves any bus rate up to 400 kHz.
  assign bus.start = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[2] & ~sda_sync_q[1]; // R13
  assign bus.stop  = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[2] & sda_sync_q[1];
  assign bus.rise  = scl_sync_q[1] & ~scl_sync_q[2];
  assign bus.fall  = ~scl_sync_q[1] & scl_sync_q[2];
  assign bus.sda   = sda_sync_q[1];

  assign slave_addr = {`NVPOT_SLAVE_BASE, asel_hi_q[1], asel_lo_q[1]};   // R9 R10
  assign byte_done  = (bitcnt_q == 4'h8) && bus.fall;
  assign rd_word    = reg_read(ptr_q, wiper_q, mode_q);                   // R4

  // ****************************************************************
  // Serial slave state machine.
  // ****************************************************************

  // Byte framing, acknowledge and data return.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q  <= NVPOT_IDLE;
      bitcnt_q <= 4'h0;
      shreg_q  <= 8'h00;
      idx_q    <= 2'h0;
      rw_q     <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (clock_en) begin
      if (bus.start) begin
        state_q  <= NVPOT_RECV;                                           // R16
        bitcnt_q <= 4'h0;
        idx_q    <= 2'h0;
        sda_oe   <= 1'b0;
      end else if (bus.stop) begin
        state_q <= NVPOT_IDLE;
        sda_oe  <= 1'b0;
      end else begin
        case (state_q)
          NVPOT_RECV: begin
            if (bus.rise && bitcnt_q < 4'h8) begin
              shreg_q  <= {shreg_q[6:0], bus.sda};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (byte_done) begin
              if (idx_q != 2'h0) begin
                state_q <= NVPOT_ACK;
                sda_oe  <= 1'b1;
              end else if (shreg_q[7:1] == slave_addr && !busy_q && !recall_q) begin // R15
                state_q <= NVPOT_ACK;
                sda_oe  <= 1'b1;
                rw_q    <= shreg_q[0];
              end else begin
                state_q <= NVPOT_IGNORE;                                  // R16
              end
            end
          end
          NVPOT_ACK: begin
            if (bus.fall) begin
              bitcnt_q <= 4'h0;
              if (idx_q != 2'h2) begin
                idx_q <= idx_q + 2'h1;
              end
              if (rw_q) begin
                // Reads come from the pointer, not from a sent address.
                shreg_q <= rd_word;                                       // R17
                sda_oe  <= ~rd_word[7];  // A one is sent by letting go of the line.
                state_q <= NVPOT_SEND;
              end else begin
                sda_oe  <= 1'b0;
                state_q <= NVPOT_RECV;
              end
            end
          end
          NVPOT_SEND: begin
            if (bus.fall) begin
              if (bitcnt_q == 4'h7) begin
                sda_oe  <= 1'b0;
                state_q <= NVPOT_MACK;
              end else begin
                shreg_q  <= {shreg_q[6:0], 1'b0};
                sda_oe   <= ~shreg_q[6];
                bitcnt_q <= bitcnt_q + 4'h1;
              end
            end
          end
          NVPOT_MACK: begin
            // A master NACK ends the read; the slave stays off the bus.
            if (bus.rise && bus.sda) begin
              state_q <= NVPOT_IGNORE;
            end else if (bus.fall) begin
              shreg_q  <= rd_word;
              sda_oe   <= ~rd_word[7];
              bitcnt_q <= 4'h0;
              state_q  <= NVPOT_SEND;
            end
          end
          NVPOT_IDLE, NVPOT_IGNORE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state_q <= NVPOT_IDLE;
            sda_oe  <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Register bank.
  // ****************************************************************

  // Pointer, wiper and control; a data write commits after its ack.
  always_ff @(posedge clock) begin
    if (rst) begin
      ptr_q   <= 8'h00;
      wiper_q <= nvpot_wiper_t'(`NVPOT_WIPER_RST);                        // R2
      mode_q  <= 1'(`NVPOT_CTRL_RST >> `NVPOT_MODE_BIT);                  // R7
    end else if (clock_en) begin
      if (recall_q && recall_cnt_q == 2'h0) begin
        wiper_q <= mem_rd_data;                                           // R1
      end else if (state_q == NVPOT_ACK && bus.fall && !rw_q && !bus.start) begin
        if (idx_q == 2'h1) begin
          ptr_q <= shreg_q;                                               // R17
        end else if (idx_q == 2'h2) begin
          if (ptr_q == `NVPOT_WIPER_ADDR) begin
            wiper_q <= shreg_q[6:0];                                      // R14 R19
          end else if (ptr_q == `NVPOT_CTRL_ADDR) begin
            // Only the mode flag is stored; nothing else moves.
            mode_q <= shreg_q[`NVPOT_MODE_BIT];                           // R3 R6 R18
          end
        end
      end
    end
  end

  // ****************************************************************
  // Nonvolatile programming and power-up recall.
  // ****************************************************************

  // Pending flag: a wiper write in mode zero waits for the closing STOP.
  always_ff @(posedge clock) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (clock_en) begin
      if (bus.start || bus.stop) begin
        pend_q <= 1'b0;                                                   // R14
      end else if (state_q == NVPOT_ACK && bus.fall && !rw_q && idx_q == 2'h2 &&
                   ptr_q == `NVPOT_WIPER_ADDR && !mode_q) begin
        pend_q <= 1'b1;                                                   // R5
      end
    end
  end

  assign mem_wr = bus.stop && pend_q;                                     // R11

  // Programming interval; the device stays silent on the bus throughout.
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_q     <= 1'b0;
      prog_cnt_q <= 32'h0000_0000;
    end else if (clock_en) begin
      if (mem_wr) begin
        busy_q     <= 1'b1;                                               // R11
        prog_cnt_q <= 32'(PROG_CYCLES - 1);
      end else if (busy_q) begin
        if (prog_cnt_q == 32'h0000_0000) begin
          busy_q <= 1'b0;
        end else begin
          prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
        end
      end
    end
  end

  // Recall sequencer: read request held two cycles; the wiper takes the registered data in the second.
  always_ff @(posedge clock) begin
    if (rst) begin
      recall_q     <= 1'b1;
      recall_cnt_q <= 2'(`NVPOT_RECALL_CYCLES - 1);
    end else if (clock_en && recall_q) begin
      if (recall_cnt_q == 2'h0) begin
        recall_q <= 1'b0;                                                 // R12
      end else begin
        recall_cnt_q <= recall_cnt_q - 2'h1;
      end
    end
  end

  assign mem_rd = recall_q;

  nvpot_nvmem #(
    .WIDTH (7)
  ) u_nvmem (
    .clock     (clock),
    .clock_en  (clock_en),
    .wr_en     (mem_wr),
    .wr_data   (wiper_q),
    .rd_en     (mem_rd),
    .rd_data_q (mem_rd_data)
  );

  // ****************************************************************
  // Registered outputs.
  // ****************************************************************

  // The tap select follows the wiper value directly, 0 to 127.
  always_ff @(posedge clock) begin
    if (rst) begin
      wiper_tap   <= 7'h00;
      eeprom_busy <= 1'b0;
      recall_done <= 1'b0;
      sda_out     <= 1'b0;
    end else if (clock_en) begin
      wiper_tap   <= wiper_q;                                             // R8
      eeprom_busy <= busy_q;
      recall_done <= ~recall_q;
      sda_out     <= 1'b0;
    end
  end

endmodule // nvpot_bank

// ==== testbench/nvpot_bank_props.sv ====
`timescale 1ns/10ps
// ******************************************
// Port-level checks of the register bank.
// ******************************************
module nvpot_bank_props
  import nvpot_pkg::*;
#(
  parameter int PROG_CYCLES = 300
) (
  input wire logic       clock,
  input wire logic       clock_en,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       addr_select_low_bit,
  input wire logic       addr_select_high_bit,
  input wire logic [6:0] wiper_tap,
  input wire logic       eeprom_busy,
  input wire logic       recall_done
);
  logic [31:0] busy_cnt_q;
  logic [3:0]  stop_age_q;
  logic        scl_d_q;
  logic        sda_d_q;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Length of the running programming interval.
  always_ff @(posedge clock) begin
    busy_cnt_q <= (rst || !eeprom_busy) ? 32'h0000_0000 : busy_cnt_q + 32'h0000_0001;
  end

  // Cycles since a STOP on the raw pins; it saturates so a long idle never wraps.
  always_ff @(posedge clock) begin
    scl_d_q <= scl_in;
    sda_d_q <= sda_in;
    if (rst) stop_age_q <= 4'hf;
    else if (scl_in && scl_d_q && sda_in && !sda_d_q) stop_age_q <= 4'h0;
    else if (stop_age_q != 4'hf) stop_age_q <= stop_age_q + 4'h1;
  end

  prog_length_a: assert property ($fell(eeprom_busy) |->
    busy_cnt_q inside {[PROG_CYCLES-1:PROG_CYCLES+1]}) else $error("bad program length");
  prog_after_stop_a: assert property ($rose(eeprom_busy) |-> stop_age_q <= 4'h8)
    else $error("programming began without a stop");
  busy_no_ack_a: assert property (eeprom_busy |-> !sda_oe)
    else $error("ack while programming");
  busy_wiper_a: assert property (eeprom_busy && $past(eeprom_busy) |-> $stable(wiper_tap))
    else $error("tap moved while programming");
  recall_time_a: assert property ($fell(rst) |-> ##[0:8] recall_done)
    else $error("recall too slow");
  recall_hold_a: assert property (recall_done |=> recall_done)
    else $error("recall flag dropped");
  recall_no_ack_a: assert property (!recall_done |-> !sda_oe)
    else $error("ack before recall");
  open_drain_a: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");

  busy_c: cover property ($rose(eeprom_busy));
  ack_c: cover property ($rose(sda_oe));
  recall_c: cover property ($rose(recall_done));
endmodule // nvpot_bank_props

bind nvpot_bank nvpot_bank_props #(.PROG_CYCLES(PROG_CYCLES)) i_nvpot_bank_props (
  .clock, .clock_en, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_select_low_bit,
  .addr_select_high_bit, .wiper_tap, .eeprom_busy, .recall_done);

// ==== testbench/nvpot_i2c_master.sv ====
`timescale 1ns/10ps
// ******************************************
// Bus master; the clock stands still between frames.
// ******************************************
module nvpot_i2c_master (
  input wire logic clock,
  input wire logic sda_line,
  output logic     scl,
  output logic     sda_low
);
  // Idle bus: both lines released.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Also serves as repeated start; waits out the slave's ack release first.
  task automatic start();
    sda_low = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(8);
  endtask

  // One 80 ns bit; data moves only while the clock is low.
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_low = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    s = sda_line;
    tick(2);
    scl = 1'b0;
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic rd(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
endmodule // nvpot_i2c_master

// ==== testbench/nvpot_bank_test.sv ====
`timescale 1ns/10ps
// ******************************************
// Register bank reached over the serial bus.
// ******************************************
module nvpot_bank_test;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       sel_lo = 1'b0;
  logic       sel_hi = 1'b0;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       eeprom_busy;
  logic       recall_done;
  logic [6:0] wiper_tap;
  logic [7:0] dev;
  int         bad_count = 0;
  int         check_count = 0;
  int         cycles = 0;
  // Pulled up: the line is high unless a party pulls it low.
  wire        sda_line = !(sda_oe === 1'b1 || sda_low);

  nvpot_bank #(.PROG_CYCLES(300)) i_nvpot_bank (.clock, .clock_en(1'b1), .rst,
    .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe, .addr_select_low_bit(sel_lo),
    .addr_select_high_bit(sel_hi), .wiper_tap, .eeprom_busy, .recall_done);
  nvpot_i2c_master i_nvpot_i2c_master (.clock, .sda_line, .scl, .sda_low);

  always #5 clock = ~clock;

  // A hung handshake must not stall the run forever.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_tap(input logic [7:0] exp);
    chk({1'b0, wiper_tap}, exp);
  endtask

  task automatic power_cycle();
    rst = 1'b1;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    repeat (10) @(posedge clock);
    #1;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 600 && eeprom_busy !== 1'b0; i++) @(posedge clock);
    #1;
  endtask

  task automatic probe(input logic [7:0] addr, output logic ack);
    i_nvpot_i2c_master.start();
    i_nvpot_i2c_master.wr(addr, ack);
    i_nvpot_i2c_master.stop();
  endtask

  // Pointer then data; a repeated start instead of a stop is left open for a read.
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] val, input logic rep);
    logic a0, a1, a2;
    i_nvpot_i2c_master.start();
    i_nvpot_i2c_master.wr(dev, a0);
    i_nvpot_i2c_master.wr(ptr, a1);
    i_nvpot_i2c_master.wr(val, a2);
    if (rep) i_nvpot_i2c_master.start();
    else i_nvpot_i2c_master.stop();
    chk({5'h00, a0, a1, a2}, 8'h07);
  endtask

  task automatic rd_cur(output logic [7:0] d);
    logic a;
    i_nvpot_i2c_master.wr(dev | 8'h01, a);
    i_nvpot_i2c_master.rd(1'b1, d);
    i_nvpot_i2c_master.stop();
  endtask

  task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    i_nvpot_i2c_master.start();
    i_nvpot_i2c_master.wr(dev, a);
    i_nvpot_i2c_master.wr(ptr, a);
    i_nvpot_i2c_master.start();
    rd_cur(d);
  endtask

  // Main sequence.
  initial begin
    logic [7:0] d;
    logic       a;
    dev = 8'h50;
    power_cycle();
    chk({7'h00, recall_done}, 8'h01);
    chk_tap(8'h40);
    reg_rd(8'h00, d);
    chk(d, 8'h40);
    reg_rd(8'h02, d);
    chk(d, 8'h00);
    $display("test defaults done");
    reg_wr(8'h00, 8'hd5, 1'b0);
    chk_tap(8'h55);
    chk({7'h00, eeprom_busy}, 8'h01);
    probe(dev, a);
    chk({7'h00, a}, 8'h00);
    wait_idle();
    probe(dev, a);
    chk({7'h00, a}, 8'h01);
    reg_wr(8'h00, 8'h2a, 1'b1);
    rd_cur(d);
    chk(d, 8'h2a);
    chk({7'h00, eeprom_busy}, 8'h00);
    power_cycle();
    chk_tap(8'h55);
    $display("test program done");
    reg_wr(8'h02, 8'hff, 1'b0);
    wait_idle();
    reg_rd(8'h02, d);
    chk(d, 8'h80);
    chk_tap(8'h55);
    reg_wr(8'h00, 8'h12, 1'b0);
    chk({7'h00, eeprom_busy}, 8'h00);
    chk_tap(8'h12);
    reg_rd(8'h00, d);
    chk(d, 8'h12);
    reg_wr(8'h02, 8'h00, 1'b0);
    wait_idle();
    chk_tap(8'h12);
    reg_wr(8'h01, 8'h77, 1'b0);
    reg_rd(8'h01, d);
    chk(d, 8'h00);
    power_cycle();
    chk_tap(8'h55);
    $display("test mode done");
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} = s[1:0];
      dev = {5'b01010, s[1:0], 1'b0};
      repeat (4) @(posedge clock);
      #1;
      probe(dev, a);
      chk({7'h00, a}, 8'h01);
      probe(dev ^ 8'h06, a);
      chk({7'h00, a}, 8'h00);
    end
    i_nvpot_i2c_master.start();
    i_nvpot_i2c_master.wr(dev ^ 8'h04, a);
    i_nvpot_i2c_master.wr(8'h00, a);
    i_nvpot_i2c_master.wr(8'h33, a);
    i_nvpot_i2c_master.stop();
    chk_tap(8'h55);
    $display("test address done");
    tally_and_finish();
  end
endmodule // nvpot_bank_test
